// *** pkg/pdw_pkg.sv ***
// Package: constants, types and register map of the power-down controller
// ***********************************************************************
// ***********************************************************************
`default_nettype none
package pdw_pkg;
	localparam int PA_W = 8;
	localparam int IRQ_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WAKE = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] WAKE_RST = 8'h00;
	localparam logic [1:0] OSC_HXT = 2'h0;
	localparam logic [1:0] OSC_HIGH_SPEED_INTERNAL_OSCILLATOR = 2'h1;
	localparam logic [1:0] OSC_LOW_SPEED_INTERNAL_OSCILLATOR = 2'h2;
	localparam logic [1:0] OSC_LXT = 2'h3;
	localparam logic [15:0] HXT_STAB_CYC = 16'h0080;
	localparam logic [15:0] HIGH_SPEED_INTERNAL_OSCILLATOR_STAB_CYC = 16'h0010;
	localparam logic [15:0] MIN_STAB_CYC = 16'h0001;
	localparam logic [15:0] LS_STAB_DEF = 16'h0400;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_DEEP_SLEEP_ZERO_MODE = 3'b001,
		ST_DEEP_SLEEP_ONE_MODE = 3'b010,
		ST_IDLE_ZERO_MODE = 3'b011,
		ST_IDLE_ONE_MODE = 3'b100,
		ST_HS_STAB = 3'b101,
		ST_FAST_WAKE = 3'b110,
		ST_LS_STAB = 3'b111
	} pdw_mode_t;
	typedef struct packed {
		logic sub_xtal;
		logic [1:0] osc_sel;
		logic vd_en;
		logic wdt_en;
		logic fast_wake_enable;
		logic clock_in_idle_bit;
		logic idle_select_bit;
	} pdw_ctrl_t;
	typedef struct packed {
		pdw_mode_t mode;
		pdw_ctrl_t ctrl;
		logic [PA_W-1:0] port_a_wake_enable;
		logic [PA_W-1:0] pa_prev;
		logic [IRQ_W-1:0] irq_arm;
		logic [15:0] cnt;
		logic from_deep_sleep_zero_mode;
		logic power_down_flag;
		logic watchdog_timeout_flag;
		logic high_speed_ready_flag;
		logic use_sub;
		logic sys_en;
		logic tbc_en;
		logic sub_en;
		logic wdt_run;
		logic wdt_clear;
		logic cpu_hold;
		logic resume;
		logic irq_service;
		logic pc_sp_reset;
		logic [7:0] rdata;
	} pdw_state_t;
endpackage
`default_nettype wire

// *** rtl/pdw_ctrl.sv ***
// Module: halt entry, low-power modes and wake-up sequencing
//
// The placing of the registers and the plain strobed port were left to the implementer.
`default_nettype none
module pdw_ctrl
	import pdw_pkg::*;
#(
	parameter logic [15:0] LS_STAB_CYC = LS_STAB_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_halt,
	input wire logic i_clr_wdt,
	input wire logic [PA_W-1:0] i_porta,
	input wire logic [IRQ_W-1:0] i_irq_req,
	input wire logic [IRQ_W-1:0] i_irq_en,
	input wire logic i_stack_full,
	input wire logic i_wdt_ovf,
	input wire logic i_hs_tick,
	input wire logic i_ls_tick,
	output logic [7:0] o_rdata,
	output logic o_sys_clk_en,
	output logic o_tbc_clk_en,
	output logic o_sub_clk_en,
	output logic o_slow_clk_en,
	output logic o_wdt_run,
	output logic o_wdt_clear,
	output logic o_cpu_hold,
	output logic o_use_sub_clk,
	output logic o_resume,
	output logic o_irq_service,
	output logic o_pc_sp_reset,
	output logic o_pdf,
	output logic o_to,
	output logic o_hs_ready
);
	// ***************************************************************
	// State
	// ***************************************************************
	pdw_state_t st_r;
	pdw_state_t st_nxt;
	logic low_pwr;
	logic halt_take;
	logic [PA_W-1:0] pa_fall;
	logic [IRQ_W-1:0] irq_wake;
	logic wake;
	logic [15:0] hs_lim;

	assign low_pwr = (st_r.mode == ST_DEEP_SLEEP_ZERO_MODE) || (st_r.mode == ST_DEEP_SLEEP_ONE_MODE)
		|| (st_r.mode == ST_IDLE_ZERO_MODE) || (st_r.mode == ST_IDLE_ONE_MODE);
	assign halt_take = i_halt && (st_r.mode == ST_RUN);
	assign pa_fall = st_r.pa_prev & ~i_porta & st_r.port_a_wake_enable;
	assign irq_wake = i_irq_req & st_r.irq_arm;
	assign wake = low_pwr && ((|pa_fall) || (|irq_wake) || i_wdt_ovf);

	// ***************************************************************
	// Stabilisation period of the system oscillator
	// ***************************************************************
	always_comb begin
		case (st_r.ctrl.osc_sel)
			OSC_HXT: hs_lim = HXT_STAB_CYC;
			OSC_HIGH_SPEED_INTERNAL_OSCILLATOR: hs_lim = HIGH_SPEED_INTERNAL_OSCILLATOR_STAB_CYC;
			OSC_LXT: hs_lim = st_r.from_deep_sleep_zero_mode ? HXT_STAB_CYC : MIN_STAB_CYC;
			default: hs_lim = MIN_STAB_CYC;
		endcase
	end

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.resume = 1'b0;
		st_nxt.irq_service = 1'b0;
		st_nxt.pc_sp_reset = 1'b0;
		st_nxt.wdt_clear = 1'b0;
		st_nxt.rdata = 8'h00;
		st_nxt.pa_prev = i_porta;
		// Register port
		if (i_wr) begin
			case (i_addr)
				REG_CTRL: st_nxt.ctrl = pdw_ctrl_t'(i_wdata);
				REG_WAKE: st_nxt.port_a_wake_enable = i_wdata[PA_W-1:0];
				default: st_nxt.ctrl = st_r.ctrl;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				REG_CTRL: st_nxt.rdata = st_r.ctrl;
				REG_WAKE: st_nxt.rdata = st_r.port_a_wake_enable;
				REG_STAT: st_nxt.rdata = {2'h0, st_r.use_sub,
					st_r.high_speed_ready_flag, st_r.watchdog_timeout_flag,
					st_r.power_down_flag, st_r.cpu_hold, low_pwr};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		// Clear first so that a halt in the same cycle wins
		if (i_clr_wdt) begin
			st_nxt.power_down_flag = 1'b0;
		end
		case (st_r.mode)
			ST_RUN: begin
				if (halt_take) begin
					st_nxt.power_down_flag = 1'b1;
					st_nxt.watchdog_timeout_flag = 1'b0;
					st_nxt.wdt_clear = 1'b1;
					// Requests already up are kept out of wake-up
					st_nxt.irq_arm = ~i_irq_req;
					st_nxt.from_deep_sleep_zero_mode = 1'b0;
					if (!st_r.ctrl.idle_select_bit) begin
						if (!st_r.ctrl.wdt_en && !st_r.ctrl.vd_en) begin
							st_nxt.mode = ST_DEEP_SLEEP_ZERO_MODE;
							st_nxt.from_deep_sleep_zero_mode = 1'b1;
						end else begin
							st_nxt.mode = ST_DEEP_SLEEP_ONE_MODE;
						end
					end else if (!st_r.ctrl.clock_in_idle_bit) begin
						st_nxt.mode = ST_IDLE_ZERO_MODE;
					end else begin
						st_nxt.mode = ST_IDLE_ONE_MODE;
					end
				end
			end
			ST_DEEP_SLEEP_ZERO_MODE, ST_DEEP_SLEEP_ONE_MODE, ST_IDLE_ZERO_MODE, ST_IDLE_ONE_MODE: begin
				if (wake) begin
					st_nxt.cnt = 16'h0000;
					if (i_wdt_ovf) begin
						st_nxt.watchdog_timeout_flag = 1'b1;
						st_nxt.pc_sp_reset = 1'b1;
					end else if (|(irq_wake & i_irq_en) && !i_stack_full) begin
						st_nxt.irq_service = 1'b1;
					end else begin
						// Request stays pending in the core
						st_nxt.resume = 1'b1;
					end
					if (st_r.mode == ST_IDLE_ONE_MODE) begin
						st_nxt.mode = ST_RUN;
					end else if (st_r.mode != ST_DEEP_SLEEP_ZERO_MODE
						&& st_r.ctrl.osc_sel == OSC_HXT
						&& st_r.ctrl.fast_wake_enable) begin
						st_nxt.mode = ST_FAST_WAKE;
						st_nxt.use_sub = 1'b1;
						st_nxt.high_speed_ready_flag = 1'b0;
					end else begin
						st_nxt.mode = ST_HS_STAB;
						st_nxt.high_speed_ready_flag = 1'b0;
					end
				end
			end
			ST_HS_STAB, ST_FAST_WAKE: begin
				// One counter serves both oscillators in turn
				if (i_hs_tick) begin
					st_nxt.cnt = st_r.cnt + 16'h0001;
					if (st_r.cnt + 16'h0001 >= hs_lim) begin
						st_nxt.cnt = 16'h0000;
						st_nxt.high_speed_ready_flag = 1'b1;
						st_nxt.use_sub = 1'b0;
						// Deep sleep zero always had the crystal off
						if (st_r.from_deep_sleep_zero_mode && st_r.ctrl.sub_xtal) begin
							st_nxt.mode = ST_LS_STAB;
						end else begin
							st_nxt.mode = ST_RUN;
						end
					end
				end
			end
			ST_LS_STAB: begin
				// Core already runs here; the crystal may still be settling
				if (i_ls_tick) begin
					st_nxt.cnt = st_r.cnt + 16'h0001;
					if (st_r.cnt + 16'h0001 >= LS_STAB_CYC) begin
						st_nxt.cnt = 16'h0000;
						st_nxt.mode = ST_RUN;
					end
				end
			end
			default: st_nxt.mode = ST_RUN;
		endcase
		// Clock gating follows the next mode so outputs match the mode
		st_nxt.sys_en = 1'b1;
		st_nxt.tbc_en = 1'b1;
		st_nxt.sub_en = st_r.ctrl.wdt_en || st_r.ctrl.vd_en;
		st_nxt.wdt_run = st_r.ctrl.wdt_en;
		st_nxt.cpu_hold = 1'b0;
		case (st_nxt.mode)
			ST_DEEP_SLEEP_ZERO_MODE: begin
				st_nxt.sys_en = 1'b0;
				st_nxt.tbc_en = 1'b0;
				st_nxt.sub_en = 1'b0;
				st_nxt.wdt_run = 1'b0;
				st_nxt.cpu_hold = 1'b1;
			end
			ST_DEEP_SLEEP_ONE_MODE: begin
				st_nxt.sys_en = 1'b0;
				st_nxt.tbc_en = 1'b0;
				st_nxt.cpu_hold = 1'b1;
			end
			ST_IDLE_ZERO_MODE: begin
				st_nxt.sys_en = 1'b0;
				st_nxt.sub_en = 1'b1;
				st_nxt.cpu_hold = 1'b1;
			end
			ST_IDLE_ONE_MODE: begin
				st_nxt.sub_en = 1'b1;
				st_nxt.cpu_hold = 1'b1;
			end
			ST_HS_STAB: begin
				st_nxt.sys_en = 1'b0;
				st_nxt.cpu_hold = 1'b1;
			end
			ST_FAST_WAKE: st_nxt.sub_en = 1'b1;
			default: st_nxt.cpu_hold = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
			st_r.mode <= ST_RUN;
			st_r.ctrl <= pdw_ctrl_t'(CTRL_RST);
			st_r.port_a_wake_enable <= WAKE_RST;
			st_r.high_speed_ready_flag <= 1'b1;
			st_r.sys_en <= 1'b1;
			st_r.tbc_en <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	assign o_rdata = st_r.rdata;
	assign o_sys_clk_en = st_r.sys_en;
	assign o_tbc_clk_en = st_r.tbc_en;
	assign o_sub_clk_en = st_r.sub_en;
	assign o_slow_clk_en = st_r.sub_en;
	assign o_wdt_run = st_r.wdt_run;
	assign o_wdt_clear = st_r.wdt_clear;
	assign o_cpu_hold = st_r.cpu_hold;
	assign o_use_sub_clk = st_r.use_sub;
	assign o_resume = st_r.resume;
	assign o_irq_service = st_r.irq_service;
	assign o_pc_sp_reset = st_r.pc_sp_reset;
	assign o_pdf = st_r.power_down_flag;
	assign o_to = st_r.watchdog_timeout_flag;
	assign o_hs_ready = st_r.high_speed_ready_flag;

	// ***************************************************************
	// Checks
	// ***************************************************************
	chk_deep_sleep_zero_mode_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take && !st_r.ctrl.idle_select_bit && !st_r.ctrl.wdt_en
		&& !st_r.ctrl.vd_en |=> st_r.mode == ST_DEEP_SLEEP_ZERO_MODE)
		else $error("halt did not enter deep sleep zero");
	chk_deep_sleep_zero_mode_clocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_DEEP_SLEEP_ZERO_MODE |-> !o_sys_clk_en && !o_tbc_clk_en
		&& !o_wdt_run && !o_sub_clk_en)
		else $error("clock running in deep sleep zero");
	chk_deep_sleep_one_mode_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take && !st_r.ctrl.idle_select_bit
		&& (st_r.ctrl.wdt_en || st_r.ctrl.vd_en) |=> st_r.mode == ST_DEEP_SLEEP_ONE_MODE)
		else $error("halt did not enter deep sleep one");
	chk_idle_zero_mode_clocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_IDLE_ZERO_MODE |-> !o_sys_clk_en && o_tbc_clk_en
		&& o_sub_clk_en && o_cpu_hold)
		else $error("wrong clocks in idle zero");
	chk_halt_flags: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take |=> o_pdf && !o_to && o_wdt_clear ##1 !o_wdt_clear)
		else $error("halt flags not updated");
	chk_clr_pdf: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		i_clr_wdt && !halt_take |=> !o_pdf)
		else $error("power down flag not cleared");
	chk_ovf_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		low_pwr && i_wdt_ovf |=> o_to && o_pc_sp_reset && !o_resume
		&& $stable(o_pdf))
		else $error("watchdog wake handled wrongly");
	chk_fast_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_FAST_WAKE |-> o_use_sub_clk && !o_hs_ready
		&& !o_cpu_hold)
		else $error("fast wake not on subclock");
	chk_stab_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_HS_STAB |-> o_cpu_hold && !o_hs_ready)
		else $error("core released before ready");
	chk_armed_irq: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		low_pwr && !(|pa_fall) && !i_wdt_ovf && !(|(i_irq_req & st_r.irq_arm))
		|=> $past(st_r.mode) == st_r.mode)
		else $error("woke without a valid source");

	// ***************************************************************
	// Checks on mode entry, mode clocks and wake handling
	// ***************************************************************
	chk_deep_sleep_one_mode_clocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_DEEP_SLEEP_ONE_MODE |-> !o_sys_clk_en && !o_tbc_clk_en
		&& o_cpu_hold)
		else $error("clock running in deep sleep one");
	chk_idle_zero_mode_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take && st_r.ctrl.idle_select_bit
		&& !st_r.ctrl.clock_in_idle_bit |=> st_r.mode == ST_IDLE_ZERO_MODE)
		else $error("halt did not enter idle zero");
	chk_idle_one_mode_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take && st_r.ctrl.idle_select_bit
		&& st_r.ctrl.clock_in_idle_bit |=> st_r.mode == ST_IDLE_ONE_MODE)
		else $error("halt did not enter idle one");
	chk_idle_one_mode_clocks: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_IDLE_ONE_MODE |-> o_sys_clk_en && o_tbc_clk_en
		&& o_sub_clk_en && o_cpu_hold)
		else $error("wrong clocks in idle one");
	chk_idle_one_mode_wake: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wake && st_r.mode == ST_IDLE_ONE_MODE |=> st_r.mode == ST_RUN)
		else $error("idle one wake did not return to run");
	// Watchdog keeps counting after the clear when it is enabled
	chk_wdt_keep: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		halt_take && st_r.ctrl.wdt_en |=> o_wdt_clear && o_wdt_run)
		else $error("watchdog stopped on halt");
	chk_low_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		low_pwr |-> o_cpu_hold)
		else $error("core released in low power");
	chk_wake_exit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wake |=> !low_pwr)
		else $error("wake source ignored");
	chk_one_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		$onehot0({o_resume, o_irq_service, o_pc_sp_reset}))
		else $error("more than one wake response");
	chk_pin_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		low_pwr && (|pa_fall) && !i_wdt_ovf && !(|irq_wake)
		|=> o_resume)
		else $error("pin wake did not resume");
	chk_irq_pend: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wake && !i_wdt_ovf && (|irq_wake)
		&& !((|(irq_wake & i_irq_en)) && !i_stack_full)
		|=> o_resume && !o_irq_service)
		else $error("unserviceable interrupt not resumed");
	chk_irq_serve: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wake && !i_wdt_ovf && (|(irq_wake & i_irq_en)) && !i_stack_full
		|=> o_irq_service)
		else $error("interrupt response missing");
	// The core runs while the crystal still settles
	chk_ls_stab: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_LS_STAB |-> !o_cpu_hold && o_hs_ready
		&& o_sys_clk_en)
		else $error("core held during crystal settling");
	chk_hold_stab: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		o_cpu_hold && !low_pwr |-> st_r.mode == ST_HS_STAB)
		else $error("core held outside stabilisation");
	chk_fast_entry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		wake && (st_r.mode == ST_DEEP_SLEEP_ONE_MODE || st_r.mode == ST_IDLE_ZERO_MODE)
		&& st_r.ctrl.osc_sel == OSC_HXT && st_r.ctrl.fast_wake_enable
		|=> st_r.mode == ST_FAST_WAKE)
		else $error("fast wake not taken");
	chk_sub_follow: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		st_r.mode == ST_RUN && !halt_take
		|=> o_sub_clk_en == $past(st_r.ctrl.wdt_en || st_r.ctrl.vd_en))
		else $error("subclock does not follow watchdog");
endmodule
`default_nettype wire

// *** dv/pdw_core_model.sv ***
// Core model: issues the halt and clear-watchdog instructions
`default_nettype none
module pdw_core_model (
	input wire logic i_clk,
	input wire logic i_cpu_hold,
	output logic o_halt,
	output logic o_clr_wdt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_halt = 1'b0;
		o_clr_wdt = 1'b0;
	end
	// A held core executes nothing, so wait for the hold to drop first
	task automatic exec(input bit is_halt);
		int n;
		n = 0;
		while (i_cpu_hold !== 1'b0 && n < 1000) begin
			@(posedge i_clk);
			n++;
		end
		@(posedge i_clk);
		if (is_halt) begin
			o_halt <= 1'b1;
		end else begin
			o_clr_wdt <= 1'b1;
		end
		@(posedge i_clk);
		o_halt <= 1'b0;
		o_clr_wdt <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** dv/pdw_ctrl_tb.sv ***
// Testbench: mode entry, wake sources and flags of the controller
`default_nettype none
`define PDW_CHK(nm, exp, got) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("MISMATCH %s exp %h got %h", nm, exp, got); \
	end \
end
module pdw_ctrl_tb
	import pdw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// *****
	// Stimulus and outputs
	// *****
	logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00, i_porta = 8'hff;
	logic [IRQ_W-1:0] i_irq_req = 4'h0, i_irq_en = 4'h0;
	logic i_stack_full = 1'b0, i_wdt_ovf = 1'b0;
	logic i_hs_tick = 1'b0, i_ls_tick = 1'b0;
	logic [1:0] ls_div = 2'h0;
	logic halt, clr_wdt;
	logic [7:0] o_rdata;
	logic o_sys_clk_en, o_tbc_clk_en, o_sub_clk_en, o_slow_clk_en;
	logic o_wdt_run, o_wdt_clear, o_cpu_hold, o_use_sub_clk, o_resume;
	logic o_irq_service, o_pc_sp_reset, o_pdf, o_to, o_hs_ready;
	int err_total = 0;
	int checks_done = 0;
	// Row per mode: control value, clock enables, state after wake
	logic [7:0] t_ctrl [5] = '{8'h80, 8'h08, 8'h05, 8'h03, 8'h10};
	logic [3:0] t_clk [5] = '{4'h0, 4'h3, 4'h6, 4'he, 4'h2};
	logic [2:0] t_wake [5] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h4};
	always #5 i_clk = ~i_clk;
	// Oscillator ticks are slower than the clock so counts take real time
	always @(posedge i_clk) begin
		i_hs_tick <= ~i_hs_tick;
		ls_div <= ls_div + 2'h1;
		i_ls_tick <= (ls_div == 2'h3);
	end
	pdw_ctrl #(.LS_STAB_CYC(16'h0004)) u_dut (
		.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
		.i_halt(halt), .i_clr_wdt(clr_wdt), .i_porta, .i_irq_req,
		.i_irq_en, .i_stack_full, .i_wdt_ovf, .i_hs_tick, .i_ls_tick,
		.o_rdata, .o_sys_clk_en, .o_tbc_clk_en, .o_sub_clk_en,
		.o_slow_clk_en, .o_wdt_run, .o_wdt_clear, .o_cpu_hold,
		.o_use_sub_clk, .o_resume, .o_irq_service, .o_pc_sp_reset,
		.o_pdf, .o_to, .o_hs_ready
	);
	pdw_core_model u_core (
		.i_clk, .i_cpu_hold(o_cpu_hold), .o_halt(halt),
		.o_clr_wdt(clr_wdt)
	);
	// *****
	// Bus tasks and closing
	// *****
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e,
		input string nm);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		`PDW_CHK(nm, e, o_rdata)
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	// *****
	// Main sequence
	// *****
	initial begin
		int k;
		logic [4:0] g;
		logic [2:0] e;
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		rd(REG_STAT, 8'h10, "status_rst");
		rd(REG_CTRL, CTRL_RST, "ctrl_rst");
		rd(REG_WAKE, WAKE_RST, "wake_rst");
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00, "unmapped");
		wr(REG_WAKE, 8'h01);
		for (int r = 0; r < 5; r++) begin
			wr(REG_CTRL, t_ctrl[r]);
			rd(REG_CTRL, t_ctrl[r], "ctrl");
			@(posedge i_clk);
			i_irq_req <= 4'h2;
			i_irq_en <= (r == 3) ? 4'h2 : 4'h3;
			i_stack_full <= (r == 4);
			u_core.exec(1'b1);
			#1;
			g = {o_sys_clk_en, o_tbc_clk_en, o_sub_clk_en, o_wdt_run, 1'b0};
			`PDW_CHK("sys_tbc", t_clk[r][3:2], g[4:3])
			`PDW_CHK("sub_wdt", t_clk[r][1:0], g[2:1])
			g = {o_cpu_hold, o_pdf, o_wdt_clear, o_to, o_slow_clk_en ^ o_sub_clk_en};
			`PDW_CHK("halt_flags", 5'h1c, g)
			@(posedge i_clk);
			i_porta <= 8'hfd;
			repeat (3) @(posedge i_clk);
			#1;
			`PDW_CHK("no_wake", 1'b1, o_cpu_hold)
			@(posedge i_clk);
			if (r == 0) begin
				i_porta <= 8'hfc;
			end else if (r == 1) begin
				i_wdt_ovf <= 1'b1;
			end else begin
				i_irq_req <= 4'h3;
			end
			@(posedge i_clk);
			i_wdt_ovf <= 1'b0;
			#1;
			e = {r == 1, r == 2, r == 0 || r > 2};
			g = {2'h0, o_pc_sp_reset, o_irq_service, o_resume};
			`PDW_CHK("wake_pulse", e, g[2:0])
			g = {2'h0, o_cpu_hold, o_use_sub_clk, o_hs_ready};
			`PDW_CHK("wake_state", t_wake[r], g[2:0])
			// Stabilisation runs 128 ticks at most, well inside the bound
			k = 0;
			while (!(o_cpu_hold === 1'b0 && o_use_sub_clk === 1'b0
				&& o_hs_ready === 1'b1) && k < 1000) begin
				@(posedge i_clk);
				#1;
				k++;
			end
			g = {o_sys_clk_en, o_hs_ready, o_pdf, k < 1000, o_to};
			`PDW_CHK("run", 5'h1e | (r == 1), g)
			// Crystal settling after deep sleep zero must end before halt
			repeat (24) @(posedge i_clk);
			@(posedge i_clk);
			i_porta <= 8'hff;
			i_irq_req <= 4'h0;
			i_stack_full <= 1'b0;
			u_core.exec(1'b0);
			#1;
			`PDW_CHK("pdf_clr", 1'b0, o_pdf)
		end
		rd(REG_STAT, 8'h10, "status_end");
		report_and_stop();
	end
endmodule
`default_nettype wire
